// ### verilog/asp_pkg.sv
package asp_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned CONV_60HZ_MS = 133;
   localparam int unsigned CONV_50HZ_MS = 160;
   localparam int unsigned CONV_60HZ_CYCLES = CONV_60HZ_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned CONV_50HZ_CYCLES = CONV_50HZ_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned EXT_CONV_PERIODS = 20510;
   localparam int unsigned SCK_DIV = 8;
   localparam int unsigned SCK_HALF_TICKS = SCK_DIV / 2;
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned DATA_OUT_MAX_NS = 1670000;
   // one internal conversion clock period, longest time so rounded down
   localparam int unsigned INT_TICK_CYCLES =
      DATA_OUT_MAX_NS / (WORD_BITS * SCK_DIV) / CLK_PERIOD_NS;
   localparam int unsigned EXT_OSC_MIN_HZ = 2560;
   // no oscillator edge for one slowest period means internal clock
   localparam int unsigned EXT_OSC_TIMEOUT_CYCLES =
      (1000000000 / EXT_OSC_MIN_HZ + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // output word layout
   // ----------------------------------------
   localparam int unsigned ADDR_BITS = 5;
   localparam int unsigned RESULT_BITS = 23;
   localparam int unsigned LAST_FALL = WORD_BITS - 1;
   localparam int unsigned WORD_DONE_BIT = 31;
   localparam int unsigned WORD_FILLER_BIT = 30;
   localparam int unsigned WORD_SIGN_BIT = 29;
   localparam int unsigned WORD_RES_MSB = 28;
   localparam int unsigned WORD_RES_LSB = 6;
   localparam int unsigned WORD_CHAN_MSB = 5;
   localparam int unsigned WORD_CHAN_LSB = 1;
   localparam int unsigned WORD_PARITY_BIT = 0;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [4:0] CHAN_RESET = 5'h00;
   localparam logic CS_PREV_RESET = 1'h1;
   typedef enum logic [1:0]
   {
      ASP_CONVERT = 2'b00,
      ASP_SLEEP = 2'b01,
      ASP_DATA = 2'b10
   } asp_state_e;
endpackage

// ### verilog/asp_serial_port.sv
`timescale 1ns/1ns
module asp_serial_port
#(
   parameter int unsigned CONV_60HZ_CYCLES = asp_pkg::CONV_60HZ_CYCLES,
   parameter int unsigned CONV_50HZ_CYCLES = asp_pkg::CONV_50HZ_CYCLES,
   parameter int unsigned EXT_OSC_TIMEOUT_CYCLES = asp_pkg::EXT_OSC_TIMEOUT_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe_n,
   input wire logic rejection_select_pin,
   input wire logic result_sign,
   input wire logic [22:0] result_value,
   output logic [4:0] channel_sel,
   output logic conv_start,
   output logic converting,
   output logic ext_osc_mode,
   output logic int_sck_mode
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed
   {
      asp_pkg::asp_state_e state;
      logic [24:0] conv_cnt;
      logic [9:0] tick_cnt;
      logic [15:0] osc_idle;
      logic osc_prev;
      logic ext_osc;
      logic cs_prev;
      logic sck_prev;
      logic por_pending;
      logic int_sck;
      logic gen_sck;
      logic [1:0] half_cnt;
      logic [5:0] rise_cnt;
      logic [5:0] fall_cnt;
      logic [31:0] shift;
      logic [4:0] addr_sh;
      logic [4:0] chan_active;
      logic sdo;
      logic start;
   } asp_regs_s;

   localparam asp_regs_s RESET_S = '{
      state: asp_pkg::ASP_CONVERT,
      conv_cnt: 25'h0000000,
      tick_cnt: 10'h000,
      osc_idle: 16'h0000,
      osc_prev: 1'h0,
      ext_osc: 1'h0,
      cs_prev: asp_pkg::CS_PREV_RESET,
      sck_prev: 1'h0,
      por_pending: 1'h1,
      int_sck: 1'h1,
      gen_sck: 1'h0,
      half_cnt: 2'h0,
      rise_cnt: 6'h00,
      fall_cnt: 6'h00,
      shift: 32'h00000000,
      addr_sh: asp_pkg::CHAN_RESET,
      chan_active: asp_pkg::CHAN_RESET,
      sdo: 1'h1,
      start: 1'h0
   };

   asp_regs_s s_reg;
   asp_regs_s s_next;

   logic cs_fall;
   logic osc_rise;
   logic conv_tick;
   logic gen_rise;
   logic gen_fall;
   logic sck_rise;
   logic sck_fall;
   logic conv_step;
   logic start_conv;
   logic [24:0] conv_target;

   // ----------------------------------------
   // output word
   // ----------------------------------------
   function automatic logic [31:0] build_word
   (
      input logic sign,
      input logic [22:0] value,
      input logic [4:0] chan
   );
      logic [31:0] w;
      w = 32'h00000000;
      w[asp_pkg::WORD_DONE_BIT] = 1'b0;
      w[asp_pkg::WORD_FILLER_BIT] = 1'b0;
      w[asp_pkg::WORD_SIGN_BIT] = sign;
      w[asp_pkg::WORD_RES_MSB:asp_pkg::WORD_RES_LSB] = value;
      w[asp_pkg::WORD_CHAN_MSB:asp_pkg::WORD_CHAN_LSB] = chan;
      // even parity over the upper 31 bits
      w[asp_pkg::WORD_PARITY_BIT] = ^w[31:1];
      return w;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.start = 1'b0;
      s_next.osc_prev = rejection_select_pin;
      s_next.cs_prev = cs_n;
      s_next.sck_prev = sck_in;
      cs_fall = s_reg.cs_prev & ~cs_n;
      osc_rise = rejection_select_pin & ~s_reg.osc_prev;
      gen_rise = 1'b0;
      gen_fall = 1'b0;
      start_conv = 1'b0;
      conv_tick = 1'b0;

      // a toggling select pin means an external oscillator
      if (osc_rise)
      begin
         s_next.osc_idle = 16'h0000;
         s_next.ext_osc = 1'b1;
      end
      else if (s_reg.osc_idle == 16'(EXT_OSC_TIMEOUT_CYCLES - 1))
      begin
         s_next.ext_osc = 1'b0;
      end
      else
      begin
         s_next.osc_idle = s_reg.osc_idle + 16'h0001;
      end

      // conversion clock tick
      if (s_reg.ext_osc)
      begin
         conv_tick = osc_rise;
         s_next.tick_cnt = 10'h000;
      end
      else if (s_reg.tick_cnt == 10'(asp_pkg::INT_TICK_CYCLES - 1))
      begin
         conv_tick = 1'b1;
         s_next.tick_cnt = 10'h000;
      end
      else
      begin
         s_next.tick_cnt = s_reg.tick_cnt + 10'h001;
      end

      // clock mode is caught just after reset and at each select fall
      if (s_reg.por_pending)
      begin
         s_next.por_pending = 1'b0;
         s_next.int_sck = sck_in;
      end
      else if (cs_fall)
      begin
         s_next.int_sck = sck_in;
      end

      // internal serial clock, four conversion ticks per half period
      if (s_reg.int_sck && !cs_n && s_reg.state != asp_pkg::ASP_CONVERT)
      begin
         if (conv_tick)
         begin
            if (s_reg.half_cnt == 2'(asp_pkg::SCK_HALF_TICKS - 1))
            begin
               s_next.half_cnt = 2'h0;
               s_next.gen_sck = ~s_reg.gen_sck;
               gen_rise = ~s_reg.gen_sck;
               gen_fall = s_reg.gen_sck;
            end
            else
            begin
               s_next.half_cnt = s_reg.half_cnt + 2'h1;
            end
         end
      end
      else
      begin
         s_next.half_cnt = 2'h0;
         s_next.gen_sck = 1'b0;
      end

      // edges only count while selected
      sck_rise = ~cs_n & (s_reg.int_sck ? gen_rise : (sck_in & ~s_reg.sck_prev));
      sck_fall = ~cs_n & (s_reg.int_sck ? gen_fall : (~sck_in & s_reg.sck_prev));

      if (s_reg.ext_osc)
      begin
         conv_step = conv_tick;
         conv_target = 25'(asp_pkg::EXT_CONV_PERIODS);
      end
      else
      begin
         conv_step = 1'b1;
         conv_target = rejection_select_pin ? 25'(CONV_50HZ_CYCLES) : 25'(CONV_60HZ_CYCLES);
      end

      case (s_reg.state)
         asp_pkg::ASP_CONVERT:
         begin
            if (conv_step)
            begin
               if (s_reg.conv_cnt >= conv_target - 25'h0000001)
               begin
                  // sleep regardless of select; result loaded for shifting
                  s_next.state = asp_pkg::ASP_SLEEP;
                  s_next.conv_cnt = 25'h0000000;
                  s_next.shift = build_word(result_sign, result_value, s_reg.chan_active);
               end
               else
               begin
                  s_next.conv_cnt = s_reg.conv_cnt + 25'h0000001;
               end
            end
         end
         asp_pkg::ASP_SLEEP:
         begin
            if (sck_rise)
            begin
               s_next.state = asp_pkg::ASP_DATA;
            end
         end
         asp_pkg::ASP_DATA:
         begin
            if (cs_n)
            begin
               start_conv = 1'b1;
            end
            else if (sck_fall)
            begin
               if (s_reg.fall_cnt == 6'(asp_pkg::LAST_FALL))
               begin
                  start_conv = 1'b1;
               end
               else
               begin
                  s_next.shift = {s_reg.shift[30:0], 1'b0};
                  s_next.fall_cnt = s_reg.fall_cnt + 6'h01;
               end
            end
         end
         default:
         begin
            s_next.state = asp_pkg::ASP_CONVERT;
         end
      endcase

      // input bits are taken on rising edges outside conversion only
      if (sck_rise && s_reg.state != asp_pkg::ASP_CONVERT)
      begin
         if (s_reg.rise_cnt < 6'(asp_pkg::ADDR_BITS))
         begin
            s_next.addr_sh = {s_reg.addr_sh[3:0], sdi};
         end
         s_next.rise_cnt = s_reg.rise_cnt + 6'h01;
      end

      if (start_conv)
      begin
         s_next.state = asp_pkg::ASP_CONVERT;
         s_next.conv_cnt = 25'h0000000;
         s_next.rise_cnt = 6'h00;
         s_next.fall_cnt = 6'h00;
         s_next.start = 1'b1;
         // a partial address is dropped and the previous channel kept
         if (s_reg.rise_cnt >= 6'(asp_pkg::ADDR_BITS))
         begin
            s_next.chan_active = s_reg.addr_sh;
         end
      end

      // done flag high while converting, then the word itself
      s_next.sdo = (s_next.state == asp_pkg::ASP_CONVERT) | s_next.shift[31];
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         s_reg <= RESET_S;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign sdo_out = s_reg.sdo;
   assign sdo_oe_n = cs_n;
   assign sck_out = s_reg.gen_sck;
   // the pin is never driven in external mode
   assign sck_oe_n = ~(s_reg.int_sck & ~cs_n);
   assign channel_sel = s_reg.chan_active;
   assign conv_start = s_reg.start;
   assign converting = s_reg.state == asp_pkg::ASP_CONVERT;
   assign ext_osc_mode = s_reg.ext_osc;
   assign int_sck_mode = s_reg.int_sck;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_sdo_released: assert property (@(posedge sys_clk) disable iff (reset)
      cs_n |-> sdo_oe_n)
      else $error("serial output driven while deselected");

   a_sck_not_driven: assert property (@(posedge sys_clk) disable iff (reset)
      !sck_oe_n |-> (s_reg.int_sck && !cs_n))
      else $error("serial clock driven outside internal mode");

   a_sleep_holds: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.state == asp_pkg::ASP_SLEEP && !sck_rise) |=> s_reg.state == asp_pkg::ASP_SLEEP)
      else $error("sleep left without a rising clock");

   a_abort_restarts: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.state == asp_pkg::ASP_DATA && cs_n) |=> (converting && conv_start && sdo_out))
      else $error("deselect did not abort the transfer");

   a_last_fall_conv: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.state == asp_pkg::ASP_DATA && !cs_n && sck_fall && s_reg.fall_cnt == 6'h1F)
      |=> (converting && sdo_out))
      else $error("32nd falling edge did not start a conversion");

   a_partial_addr_kept: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.state == asp_pkg::ASP_DATA && cs_n && s_reg.rise_cnt < 6'h05)
      |=> $stable(channel_sel))
      else $error("partial address changed the channel");

   a_convert_ignores_sdi: assert property (@(posedge sys_clk) disable iff (reset)
      (converting && !conv_start) |=> ($stable(s_reg.addr_sh) && $stable(channel_sel)))
      else $error("serial input taken during conversion");

   a_mode_on_cs_fall: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.cs_prev && !cs_n && !s_reg.por_pending) |=> (int_sck_mode == $past(sck_in)))
      else $error("clock mode not sampled at select fall");

   a_eoc_converting: assert property (@(posedge sys_clk) disable iff (reset)
      (converting && !cs_n) |-> sdo_out)
      else $error("done flag low during conversion");

   a_msb_first: assert property (@(posedge sys_clk) disable iff (reset)
      (s_reg.state == asp_pkg::ASP_DATA && !cs_n && sck_fall && s_reg.fall_cnt == 6'h00)
      |=> sdo_out == $past(s_reg.shift[30]))
      else $error("first shifted bit is not the filler bit");
endmodule

// ### verif/asp_host_model.sv
`timescale 1ns/1ns
module asp_host_model
(
   input wire logic sys_clk,
   input wire logic sdo_line,
   output logic cs_n,
   output logic sck_in,
   output logic sdi
);
   logic busy;
   initial
   begin
      cs_n = 1'h1;
      sck_in = 1'h0;
      sdi = 1'h0;
      busy = 1'h0;
   end
   // sdi is released outside frames, so it toggles and never shows a stale bit
   always @(posedge sys_clk)
   begin
      if (!busy)
         sdi <= ~sdi;
   end
   // sck low at the select fall selects external clock mode
   task automatic xfer(input int nb, input logic [4:0] ch, input bit keep, output logic [31:0] w);
      int t;
      w = '0;
      t = 0;
      busy = 1'h1;
      @(posedge sys_clk) cs_n <= 1'h0;
      @(posedge sys_clk);
      @(posedge sys_clk);
      while (sdo_line !== 1'h0 && t < 1000)
      begin
         @(posedge sys_clk);
         t++;
      end
      for (int i = 0; i < nb; i++)
      begin
         @(posedge sys_clk) sdi <= (i < 5) ? ch[4 - i] : ~sdi;
         repeat (2) @(posedge sys_clk);
         w = {w[30:0], sdo_line};
         sck_in <= 1'h1;
         repeat (4) @(posedge sys_clk);
         sck_in <= 1'h0;
         repeat (2) @(posedge sys_clk);
      end
      repeat (2) @(posedge sys_clk);
      if (!keep)
         cs_n <= 1'h1;
      @(posedge sys_clk);
      busy = 1'h0;
   endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ns
module tb;
   logic sys_clk;
   logic reset;
   logic cs_n;
   logic sck_in;
   logic sck_out;
   logic sck_oe_n;
   logic sck_line;
   logic sdi;
   logic sdo_out;
   logic sdo_oe_n;
   logic sdo_line;
   logic tgl;
   logic rej;
   logic r_sign;
   logic [22:0] r_value;
   logic [4:0] channel_sel;
   logic conv_start;
   logic converting;
   logic ext_osc_mode;
   logic int_sck_mode;
   logic [31:0] w;
   int conv_cyc;
   int n_fail;
   int checks;
   // ----------------------------------------
   // clock, wires, instances
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) tgl <= ~tgl;
   // counts convert cycles from the start pulse, so late callers still see the full length
   always @(posedge sys_clk) conv_cyc <= conv_start ? 1 : (converting ? conv_cyc + 1 : conv_cyc);
   assign sck_line = sck_oe_n ? sck_in : sck_out;
   assign sdo_line = sdo_oe_n ? tgl : sdo_out;
   asp_host_model u_asp_host_model
   (
      .sys_clk(sys_clk),
      .sdo_line(sdo_line),
      .cs_n(cs_n),
      .sck_in(sck_in),
      .sdi(sdi)
   );
   asp_serial_port #(.CONV_60HZ_CYCLES(200), .CONV_50HZ_CYCLES(300), .EXT_OSC_TIMEOUT_CYCLES(64)) u_asp_serial_port
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .cs_n(cs_n),
      .sck_in(sck_line),
      .sck_out(sck_out),
      .sck_oe_n(sck_oe_n),
      .sdi(sdi),
      .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n),
      .rejection_select_pin(rej),
      .result_sign(r_sign),
      .result_value(r_value),
      .channel_sel(channel_sel),
      .conv_start(conv_start),
      .converting(converting),
      .ext_osc_mode(ext_osc_mode),
      .int_sck_mode(int_sck_mode)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] word_of(input logic s, input logic [22:0] v, input logic [4:0] c);
      logic [31:0] x;
      x = {2'h0, s, v, c, 1'h0};
      x[0] = ^x[31:1];
      return x;
   endfunction
   // length of the conversion that has just begun, in sys_clk cycles
   task automatic conv_len(output logic [31:0] n);
      int t;
      t = 0;
      while (converting === 1'h1 && t < 2000)
      begin
         @(negedge sys_clk);
         t++;
      end
      n = conv_cyc;
   endtask
   task automatic end_of_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_status;
      int t;
      t = 0;
      @(posedge sys_clk) u_asp_host_model.cs_n <= 1'h0;
      @(negedge sys_clk);
      chk(sdo_oe_n, 1'h0);
      chk(sdo_out, 1'h1);
      while (converting === 1'h1 && t < 1000)
      begin
         @(negedge sys_clk);
         t++;
      end
      @(negedge sys_clk);
      chk(sdo_out, 1'h0);
      @(posedge sys_clk) u_asp_host_model.cs_n <= 1'h1;
      @(negedge sys_clk);
      chk(sdo_oe_n, 1'h1);
      @(posedge sys_clk) u_asp_host_model.sck_in <= 1'h1;
      @(posedge sys_clk) u_asp_host_model.cs_n <= 1'h0;
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk(int_sck_mode, 1'h1);
      chk(sck_oe_n, 1'h0);
      chk(sdo_out, 1'h0);
      @(posedge sys_clk);
      u_asp_host_model.cs_n <= 1'h1;
      u_asp_host_model.sck_in <= 1'h0;
      @(negedge sys_clk);
      chk(sck_oe_n, 1'h1);
      $display("test status done");
   endtask
   task automatic t_read;
      logic [31:0] n;
      u_asp_host_model.xfer(32, 5'h13, 1'b0, w);
      chk(w, word_of(1'h1, 23'h4C3B2A, 5'h00));
      chk(int_sck_mode, 1'h0);
      chk(sck_oe_n, 1'h1);
      chk(converting, 1'h1);
      chk(sdo_out, 1'h1);
      chk(channel_sel, 5'h13);
      r_value <= 23'h1234AB;
      conv_len(n);
      chk(n, 200);
      $display("test read done");
   endtask
   task automatic t_abort;
      logic [31:0] n;
      rej <= 1'h1;
      // a single select edge looks like an oscillator edge; let that detection time out first
      repeat (80) @(posedge sys_clk);
      u_asp_host_model.xfer(3, 5'h07, 1'b0, w);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk(converting, 1'h1);
      chk(channel_sel, 5'h13);
      r_sign <= 1'h0;
      conv_len(n);
      chk(n, 300);
      $display("test abort done");
   endtask
   task automatic t_cont;
      u_asp_host_model.xfer(32, 5'h0A, 1'b1, w);
      chk(w, word_of(1'h0, 23'h1234AB, 5'h13));
      rej <= 1'h0;
      u_asp_host_model.xfer(32, 5'h1F, 1'b0, w);
      chk(w, word_of(1'h0, 23'h1234AB, 5'h0A));
      chk(ext_osc_mode, 1'h0);
      $display("test continuous done");
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      n_fail = 0;
      checks = 0;
      tgl = 1'h0;
      rej = 1'h0;
      r_sign = 1'h1;
      r_value = 23'h4C3B2A;
      reset = 1'h1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'h0;
      t_status;
      t_read;
      t_abort;
      t_cont;
      end_of_test;
   end
   // the tests take about 2000 cycles; the margin covers every bounded wait
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_fail++;
      end_of_test;
   end
endmodule
